// [src/asr_top.sv]
`timescale 1ns/1ps
module asr_top #(
	parameter int unsigned CONV_NS = asr_pkg::T_CONV_DEF_NS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Host pins, asynchronous to clk_i
	input wire logic convert_strobe_i,
	input wire logic select_serial_in_i,
	input wire logic shift_clk_i,
	// Board strap: high on the chain member whose input is grounded
	input wire logic chain_head_i,
	// Converter core result, same clock domain
	input wire logic [asr_pkg::RES_W-1:0] conv_result_i,
	// Serial output pin
	output logic serial_result_out_o,
	output logic serial_result_oe_o,
	// Converter core status
	output logic converting_o,
	output logic power_down_o
);
	import asr_pkg::*;

	localparam logic [CNT_W-1:0] CONV_CYC =
		CNT_W'((CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	logic [SYNC_W-1:0] pins_async;
	logic [SYNC_W-1:0] pins_sync;
	logic stb_s;
	logic sdi_s;
	logic sck_s;
	logic head_s;
	logic stb_prev_reg;
	logic sdi_prev_reg;
	logic sck_prev_reg;
	logic stb_rise;
	logic sdi_rise;
	logic sdi_fall;
	logic sck_fall;

	asr_state_t state_reg;
	asr_mode_t mode_reg;
	logic [CNT_W-1:0] conv_cnt_reg;
	logic [BITCNT_W-1:0] edge_cnt_reg;
	logic lead_reg;
	logic conv_end;
	logic [RES_W-1:0] sh_q;
	logic sh_load;
	logic sh_shift;
	logic [CNT_W-1:0] conv_len_reg;

	function automatic logic is_readout(input asr_state_t s);
		is_readout = (s == ASR_ST_BUSY_WAIT) || (s == ASR_ST_SHIFT) || (s == ASR_ST_DONE);
	endfunction

	assign pins_async = {chain_head_i, shift_clk_i, select_serial_in_i, convert_strobe_i};

	asr_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.async_i(pins_async),
		.sync_o(pins_sync)
	);

	assign stb_s = pins_sync[PIN_STB];
	assign sdi_s = pins_sync[PIN_SDI];
	assign sck_s = pins_sync[PIN_SCK];
	assign head_s = pins_sync[PIN_HEAD];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stb_prev_reg <= 1'b0;
			sdi_prev_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
		end else begin
			stb_prev_reg <= stb_s;
			sdi_prev_reg <= sdi_s;
			sck_prev_reg <= sck_s;
		end
	end

	assign stb_rise = stb_s && !stb_prev_reg;
	assign sdi_rise = sdi_s && !sdi_prev_reg;
	assign sdi_fall = !sdi_s && sdi_prev_reg;
	assign sck_fall = !sck_s && sck_prev_reg;

	// Conversion timer on the internal clock
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_cnt_reg <= '0;
		end else if (stb_rise && state_reg != ASR_ST_CONV) begin
			conv_cnt_reg <= CONV_CYC;
		end else if (state_reg == ASR_ST_CONV && conv_cnt_reg != '0) begin
			conv_cnt_reg <= conv_cnt_reg - CNT_W'(1);
		end
	end

	assign conv_end = (state_reg == ASR_ST_CONV) && (conv_cnt_reg == CNT_W'(1));

	// Mode is fixed by the levels seen at the strobe rise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= ASR_MODE_SEL;
		end else if (stb_rise && state_reg != ASR_ST_CONV) begin
			if (sdi_s) begin
				mode_reg <= ASR_MODE_SEL;
			end else if (sck_s) begin
				mode_reg <= ASR_MODE_CHAIN_BUSY;
			end else begin
				mode_reg <= ASR_MODE_CHAIN;
			end
		end
	end

	// A conversion, once started, ignores the strobe until it ends
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ASR_ST_IDLE;
		end else begin
			case (state_reg)
				ASR_ST_CONV: begin
					if (conv_end) begin
						if (mode_reg == ASR_MODE_CHAIN) begin
							state_reg <= ASR_ST_SHIFT;
						end else if (mode_reg == ASR_MODE_CHAIN_BUSY || !sdi_s) begin
							state_reg <= ASR_ST_BUSY_WAIT;
						end else begin
							state_reg <= ASR_ST_WAIT_SEL;
						end
					end
				end
				default: begin
					if (stb_rise) begin
						state_reg <= ASR_ST_CONV;
					end else if (!stb_s) begin
						state_reg <= ASR_ST_IDLE;
					end else if (state_reg == ASR_ST_WAIT_SEL && sdi_fall) begin
						state_reg <= ASR_ST_SHIFT;
					end else if (mode_reg == ASR_MODE_SEL && is_readout(state_reg)
						&& (sdi_rise || (sck_fall && edge_cnt_reg == CS_RELEASE_EDGE
						- BITCNT_W'(1)))) begin
						state_reg <= ASR_ST_DONE;
					end else if (state_reg == ASR_ST_BUSY_WAIT && sck_fall) begin
						state_reg <= ASR_ST_SHIFT;
					end
				end
			endcase
		end
	end

	// Falling clock edges seen during readout
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			edge_cnt_reg <= '0;
		end else if (state_reg == ASR_ST_CONV) begin
			edge_cnt_reg <= '0;
		end else if (is_readout(state_reg) && sck_fall && edge_cnt_reg != CS_RELEASE_EDGE) begin
			edge_cnt_reg <= edge_cnt_reg + BITCNT_W'(1);
		end
	end

	// Busy modes spend the first fall presenting the MSB without shifting
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lead_reg <= 1'b0;
		end else if (conv_end) begin
			lead_reg <= (mode_reg == ASR_MODE_CHAIN_BUSY) || (mode_reg == ASR_MODE_SEL && !sdi_s);
		end else if (sck_fall) begin
			lead_reg <= 1'b0;
		end
	end

	assign sh_load = conv_end;
	assign sh_shift = sck_fall && is_readout(state_reg) && !lead_reg
		&& state_reg == ASR_ST_SHIFT;

	asr_shifter u_shift (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.load_i(sh_load),
		.shift_i(sh_shift),
		.load_data_i(conv_result_i),
		.ser_i(sdi_s),
		.q_o(sh_q)
	);

	// Output pin; while shifting, the value changes only on clock falls, so it holds across the rise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serial_result_out_o <= 1'b0;
			serial_result_oe_o <= 1'b0;
		end else if (!stb_s && !sdi_s) begin
			serial_result_out_o <= 1'b0;
			serial_result_oe_o <= 1'b1;
		end else if (!stb_s || state_reg == ASR_ST_DONE) begin
			serial_result_oe_o <= 1'b0;
		end else if (stb_rise && state_reg != ASR_ST_CONV) begin
			serial_result_oe_o <= !sdi_s;
			serial_result_out_o <= 1'b0;
		end else if (state_reg == ASR_ST_BUSY_WAIT && mode_reg == ASR_MODE_CHAIN_BUSY
			&& !sck_fall) begin
			serial_result_oe_o <= 1'b1;
			serial_result_out_o <= head_s || sdi_s;
		end else if (conv_end && mode_reg == ASR_MODE_CHAIN) begin
			serial_result_oe_o <= 1'b1;
			serial_result_out_o <= conv_result_i[RES_W-1];
		end else if (conv_end && (mode_reg == ASR_MODE_CHAIN_BUSY || !sdi_s)) begin
			serial_result_oe_o <= 1'b1;
			serial_result_out_o <= 1'b0;
		end else if (state_reg == ASR_ST_WAIT_SEL && sdi_fall) begin
			serial_result_oe_o <= 1'b1;
			serial_result_out_o <= sh_q[RES_W-1];
		end else if (is_readout(state_reg) && sck_fall) begin
			serial_result_oe_o <= 1'b1;
			if (mode_reg == ASR_MODE_SEL && edge_cnt_reg == CS_RELEASE_EDGE - BITCNT_W'(1)) begin
				serial_result_oe_o <= 1'b0;
			end else if (lead_reg) begin
				serial_result_out_o <= sh_q[RES_W-1];
			end else begin
				serial_result_out_o <= sh_q[RES_W-2];
			end
		end
	end

	// Core runs only while converting
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			converting_o <= 1'b0;
			power_down_o <= 1'b1;
		end else begin
			converting_o <= (stb_rise && state_reg != ASR_ST_CONV)
				|| (state_reg == ASR_ST_CONV && !conv_end);
			power_down_o <= !((stb_rise && state_reg != ASR_ST_CONV)
				|| (state_reg == ASR_ST_CONV && !conv_end));
		end
	end

	// Measured length, so a bad load value or a stuck timer shows up
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_len_reg <= '0;
		end else if (!converting_o) begin
			conv_len_reg <= '0;
		end else if (conv_len_reg != '1) begin
			conv_len_reg <= conv_len_reg + CNT_W'(1);
		end
	end

	a_conv_window: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$fell(converting_o) |-> (conv_len_reg >= CNT_W'(CONV_MIN_CYC)
		&& conv_len_reg <= CNT_W'(CONV_MAX_CYC)))
		else $error("conversion window out of range");

	a_mode_latch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(stb_rise && state_reg != ASR_ST_CONV && sdi_s) |=> mode_reg == ASR_MODE_SEL)
		else $error("select mode not latched");

	a_chain_busy_pick: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(stb_rise && state_reg != ASR_ST_CONV && !sdi_s && sck_s)
		|=> mode_reg == ASR_MODE_CHAIN_BUSY)
		else $error("chain busy mode not latched");

	a_chain_plain_pick: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(stb_rise && state_reg != ASR_ST_CONV && !sdi_s && !sck_s)
		|=> mode_reg == ASR_MODE_CHAIN)
		else $error("chain mode not latched");

	a_start_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(stb_rise && state_reg != ASR_ST_CONV && sdi_s)
		|=> !serial_result_oe_o && state_reg == ASR_ST_CONV)
		else $error("select start did not release output");

	a_both_low_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!stb_s && !sdi_s) |=> serial_result_oe_o && !serial_result_out_o)
		else $error("output not driven low");

	a_sel_busy_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(conv_end && mode_reg == ASR_MODE_SEL && !sdi_s && stb_s)
		|=> serial_result_oe_o && !serial_result_out_o)
		else $error("busy low missing");

	a_chain_msb: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(conv_end && mode_reg == ASR_MODE_CHAIN && stb_s)
		|=> serial_result_oe_o && serial_result_out_o == $past(conv_result_i[RES_W-1]))
		else $error("chain MSB not presented");

	a_release_sdi: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(mode_reg == ASR_MODE_SEL && state_reg == ASR_ST_SHIFT && stb_s && sdi_rise)
		|=> ##1 !serial_result_oe_o)
		else $error("output not released on select rise");

	a_power_down: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		conv_end |=> power_down_o && !converting_o)
		else $error("core not powered down");

endmodule

// [src/asr_pkg.sv]
package asr_pkg;

	// Clock of the readout logic
	localparam int unsigned CLK_PERIOD_PS = 25000;

	// Conversion window, in nanoseconds
	localparam int unsigned T_CONV_MIN_NS = 500;
	localparam int unsigned T_CONV_MAX_NS = 2200;
	localparam int unsigned T_CONV_DEF_NS = 1600;

	// Least time rounds up, longest time rounds down
	localparam int unsigned CONV_MIN_CYC = (T_CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned CONV_MAX_CYC = (T_CONV_MAX_NS * 1000) / CLK_PERIOD_PS;

	// Result word and serial framing
	localparam int unsigned RES_W = 16;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned BITCNT_W = 5;
	localparam logic [BITCNT_W-1:0] CS_RELEASE_EDGE = 5'h11;
	localparam int unsigned SYNC_W = 4;

	// Positions inside the synchronised pin vector
	localparam int unsigned PIN_STB = 0;
	localparam int unsigned PIN_SDI = 1;
	localparam int unsigned PIN_SCK = 2;
	localparam int unsigned PIN_HEAD = 3;

	typedef enum logic [1:0] {
		ASR_MODE_SEL = 2'b00,
		ASR_MODE_CHAIN = 2'b01,
		ASR_MODE_CHAIN_BUSY = 2'b10
	} asr_mode_t;

	typedef enum logic [2:0] {
		ASR_ST_IDLE = 3'b000,
		ASR_ST_CONV = 3'b001,
		ASR_ST_WAIT_SEL = 3'b010,
		ASR_ST_BUSY_WAIT = 3'b011,
		ASR_ST_SHIFT = 3'b100,
		ASR_ST_DONE = 3'b101
	} asr_state_t;

endpackage

// [src/asr_sync.sv]
`timescale 1ns/1ps
module asr_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= '0;
			sync_o <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end

endmodule

// [src/asr_shifter.sv]
`timescale 1ns/1ps
module asr_shifter (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic load_i,
	input wire logic shift_i,
	input wire logic [asr_pkg::RES_W-1:0] load_data_i,
	input wire logic ser_i,
	// Register contents
	output logic [asr_pkg::RES_W-1:0] q_o
);
	import asr_pkg::*;

	// Load has priority so a fresh result never loses its MSB
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_o <= '0;
		end else if (load_i) begin
			q_o <= load_data_i;
		end else if (shift_i) begin
			q_o <= {q_o[RES_W-2:0], ser_i};
		end
	end

endmodule

// [sim/asr_host.sv]
`timescale 1ns/1ps
module asr_host (
	// Clock
	input wire logic clk_i,
	// Serial line as the host sees it
	input wire logic sdo_wire_i,
	// Host pins
	output logic strobe_o,
	output logic sel_o,
	output logic sck_o
);
	initial begin
		strobe_o = 1'b0;
		sel_o = 1'b0;
		sck_o = 1'b0;
	end
	// Pins move just after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic start(input int m);
		sel_o = (m == 0) || (m == 3);
		sck_o = (m == 2);
		tick(2);
		strobe_o = 1'b1;
		tick(5);
		sel_o = (m == 3);
	endtask
	// Bit k is sampled in the high phase, before fall k+1
	task automatic frame(input int n, input logic [31:0] up, output logic [63:0] got);
		for (int k = 0; k <= n; k++) begin
			if (k > 0) begin
				sck_o = 1'b0;
				tick(4);
			end
			sck_o = 1'b1;
			tick(3);
			got[k] = sdo_wire_i;
			if (k < 32) sel_o = up[31-k];
			tick(1);
		end
	endtask
	task automatic set_pins(input logic s, input logic c, input logic k);
		strobe_o = s;
		sel_o = c;
		sck_o = k;
		tick(4);
	endtask
endmodule

// [sim/adc_serial_readout_busy_chain_tb.sv]
`timescale 1ns/1ps
module adc_serial_readout_busy_chain_tb;
	import asr_pkg::*;
	// Shorter conversion keeps the run brief
	localparam int unsigned CONV_NS = 800;
	localparam int CONV_CYC = CONV_NS * 1000 / CLK_PERIOD_PS;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [RES_W-1:0] res = '0;
	logic head = 1'b1;
	logic serial_result_out, oe, conv, pd, strobe, sel, sck, wire_lvl;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [31:0] rng = 32'd46993;
	always #12.5 clk_i = ~clk_i;
	// Pull-up on the line when released
	assign wire_lvl = oe ? serial_result_out : 1'b1;
	asr_top #(.CONV_NS(CONV_NS)) dut_u (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.convert_strobe_i(strobe),
		.select_serial_in_i(sel),
		.shift_clk_i(sck),
		.chain_head_i(head),
		.conv_result_i(res),
		.serial_result_out_o(serial_result_out),
		.serial_result_oe_o(oe),
		.converting_o(conv),
		.power_down_o(pd)
	);
	asr_host host_u (
		.clk_i(clk_i),
		.sdo_wire_i(wire_lvl),
		.strobe_o(strobe),
		.sel_o(sel),
		.sck_o(sck)
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic exp_bit(input int m, input logic [15:0] r, input logic [31:0] up,
		input int k, input logic h);
		logic [47:0] st;
		st = {r, up};
		if (m == 1 || m == 3) return st[47-k];
		if (k == 0) return (m == 2) && h;
		return (k <= 16) ? r[16-k] : 1'b1;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		logic [63:0] got;
		logic [31:0] up;
		int n, w, m;
		repeat (2) @(posedge clk_i);
		#2;
		arst_n_i = 1'b1;
		host_u.tick(4);
		chk({oe, serial_result_out}, 2'b10, "idle drive low");
		for (int i = 0; i < 12; i++) begin
			m = i % 4;
			rng = xs(rng);
			res = rng[15:0];
			head = rng[16];
			rng = xs(rng);
			up = (m == 1) ? rng : 32'h0;
			host_u.start(m);
			if (m == 0 || m == 3) chk(oe, 0, "released at start");
			chk(conv, 1, "converting");
			w = 5;
			while (conv === 1'b1 && w < 200) begin
				host_u.tick(1);
				w++;
			end
			chk(w >= CONV_CYC && w <= CONV_CYC + 5, 1, "conversion length");
			host_u.tick(2);
			chk(pd, 1, "acquisition power down");
			n = (m == 0) ? ((i == 4) ? 5 : 17) : ((m == 1) ? 32 : 17);
			// No busy: select fall presents the MSB
			if (m == 3) host_u.set_pins(1'b1, 1'b0, 1'b0);
			host_u.frame(n, up, got);
			for (int k = 0; k <= ((m == 2) ? 16 : ((m == 3) ? 15 : n)); k++)
				chk(got[k], exp_bit(m, res, up, k, head), "serial bit");
			if (i == 4) host_u.set_pins(1'b1, 1'b1, 1'b1);
			if (m == 0) chk(oe, 0, "released after frame");
			host_u.set_pins(1'b0, 1'b0, 1'b0);
			chk({oe, serial_result_out}, 2'b10, "select and strobe low");
			$display("test %0d mode %0d done", i, m);
		end
		tally_and_finish();
	end
endmodule
